// file: hw/pgs_cfg_mem.sv
// Purpose: small store of configuration words with registered read
// Assumes: contents preloaded by an init port before start-up
// Notes: read data come from a register
`timescale 1ns/1ps
module pgs_cfg_mem #(
    parameter int SEL_W = pgs_pkg::SEL_W,
    parameter int DATA_W = 16
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [SEL_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [SEL_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem_q [2**SEL_W];
    logic [DATA_W-1:0] rd_q;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_q <= mem_q[rd_addr];
    end

    assign rd_data = rd_q;
endmodule

// file: hw/pgs_pkg.sv
// Purpose: shared constants and types for the power-good pin sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes: pin function encodings and the configuration select width
package pgs_pkg;
    localparam int SEL_W = 2;
    localparam int SUPPLY_N = 4;
    localparam int SYNC_STAGES = 2;
    localparam logic [1:0] FUNC_NONE = 2'h0;
    localparam logic [1:0] FUNC_SLEEP = 2'h1;
    localparam logic [1:0] FUNC_REBOOT = 2'h2;
    localparam logic [1:0] FUNC_BAD = 2'h3;
    typedef enum logic [2:0] {
        PGS_WAIT,
        PGS_LOAD,
        PGS_RESTORE,
        PGS_RUN,
        PGS_SLEEP,
        PGS_RESET
    } pgs_state_t;
endpackage

// file: hw/pgs_sync.sv
// Purpose: two-flop level synchroniser for the power-good pin
// Assumes: input asynchronous to clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module pgs_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
        if (!rst_b) begin
            meta_d = RESET_VAL;
            sync_d = RESET_VAL;
        end
    end

    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_out = sync_q;
endmodule

// file: hw/pgs_top.sv
// Purpose: start-up gating from a power-good pin for a clock generator
// Assumes: pin and supply flags synchronous-ish; pin passes a synchroniser anyway
// Notes: pin function is chosen by the function select input
`timescale 1ns/1ps
module pgs_top #(
    parameter int SEL_W = pgs_pkg::SEL_W,
    parameter int SUPPLY_N = pgs_pkg::SUPPLY_N,
    parameter int CFG_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic power_ok_pin,
    input wire logic [1:0] pin_function,
    input wire logic [SUPPLY_N-1:0] supply_valid,
    input wire logic [SEL_W-1:0] cfg_select,
    input wire logic cfg_wr_en,
    input wire logic [SEL_W-1:0] cfg_wr_addr,
    input wire logic [CFG_W-1:0] cfg_wr_data,
    output logic supply_ok_indication,
    output logic clocks_enable,
    output logic analog_pll_enable,
    output logic low_power_active,
    output logic core_reset_b,
    output logic cfg_load_pulse,
    output logic cfg_restore_pulse,
    output logic [CFG_W-1:0] active_cfg
);
    logic pin_sync;
    logic pin_prev_q;
    logic pin_prev_d;
    logic pin_rise;
    logic all_supplies;
    logic sleep_mode;
    logic reboot_mode;
    logic [CFG_W-1:0] mem_rd;

    pgs_sync #(
        .RESET_VAL(1'b0)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(power_ok_pin),
        .sync_out(pin_sync)
    );

    pgs_cfg_mem #(
        .SEL_W(SEL_W),
        .DATA_W(CFG_W)
    ) u_mem (
        .clk(clk),
        .wr_en(cfg_wr_en),
        .wr_addr(cfg_wr_addr),
        .wr_data(cfg_wr_data),
        .rd_addr(cfg_select),
        .rd_data(mem_rd)
    );

    // only one of the two functions may be live
    assign sleep_mode = (pin_function == pgs_pkg::FUNC_SLEEP);
    assign reboot_mode = (pin_function == pgs_pkg::FUNC_REBOOT);
    assign all_supplies = &supply_valid;

    // edge seen once per synchronised rising level change
    assign pin_rise = pin_sync & ~pin_prev_q;

    pgs_pkg::pgs_state_t state_q;
    pgs_pkg::pgs_state_t state_d;
    logic loaded_q;
    logic loaded_d;

    logic [CFG_W-1:0] cfg_q;
    logic [CFG_W-1:0] cfg_d;

    logic ok_q;
    logic ok_d;
    logic clk_en_q;
    logic clk_en_d;
    logic pll_q;
    logic pll_d;
    logic lp_q;
    logic lp_d;
    logic crst_q;
    logic crst_d;
    logic load_q;
    logic load_d;
    logic rest_q;
    logic rest_d;

    logic gated_mode;
    logic start_ok;
    logic wake_ok;

    // pin function live at all
    assign gated_mode = sleep_mode | reboot_mode;

    // level start needs the pin and every rail
    assign start_ok = pin_sync & all_supplies;

    // waking from sleep or restart needs a fresh rise
    assign wake_ok = pin_rise & all_supplies;

    // edge detector history, cleared to the synchroniser idle level
    always_comb begin
        pin_prev_d = pin_sync;
        if (!rst_b) begin
            pin_prev_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        pin_prev_q <= pin_prev_d;
    end

    // sequencing state and the loaded flag
    always_comb begin
        state_d = state_q;
        loaded_d = loaded_q;
        case (state_q)
            pgs_pkg::PGS_WAIT: begin
                if (!gated_mode) begin
                    if (all_supplies) begin
                        state_d = pgs_pkg::PGS_LOAD;
                    end
                end else if (start_ok) begin
                    if (sleep_mode && loaded_q) begin
                        state_d = pgs_pkg::PGS_RESTORE;
                    end else begin
                        state_d = pgs_pkg::PGS_LOAD;
                    end
                end
            end

            pgs_pkg::PGS_LOAD: begin
                loaded_d = 1'b1;
                state_d = pgs_pkg::PGS_RUN;
            end

            pgs_pkg::PGS_RESTORE: begin
                state_d = pgs_pkg::PGS_RUN;
            end

            pgs_pkg::PGS_RUN: begin
                if (sleep_mode && !pin_sync) begin
                    state_d = pgs_pkg::PGS_SLEEP;
                end else if (reboot_mode && !pin_sync) begin
                    state_d = pgs_pkg::PGS_RESET;
                end else if (!all_supplies) begin
                    // a lost rail stops clocks in every mode
                    state_d = pgs_pkg::PGS_WAIT;
                end
            end

            pgs_pkg::PGS_SLEEP: begin
                if (!sleep_mode) begin
                    state_d = pgs_pkg::PGS_WAIT;
                end else if (wake_ok) begin
                    state_d = pgs_pkg::PGS_RUN;
                end
            end

            pgs_pkg::PGS_RESET: begin
                loaded_d = 1'b0;
                if (wake_ok) begin
                    state_d = pgs_pkg::PGS_LOAD;
                end
            end

            default: begin
                state_d = pgs_pkg::PGS_WAIT;
            end
        endcase
        if (!rst_b) begin
            state_d = pgs_pkg::PGS_WAIT;
            loaded_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        state_q <= state_d;
        loaded_q <= loaded_d;
    end

    // active configuration word, untouched by sleep and restore
    always_comb begin
        cfg_d = cfg_q;
        if (state_q == pgs_pkg::PGS_LOAD) begin
            // read register already holds the selected word
            cfg_d = mem_rd;
        end
        if (!rst_b) begin
            cfg_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        cfg_q <= cfg_d;
    end

    // registered enables and pulses
    always_comb begin
        ok_d = 1'b0;
        clk_en_d = 1'b0;
        pll_d = 1'b0;
        lp_d = 1'b0;
        crst_d = 1'b1;
        load_d = 1'b0;
        rest_d = 1'b0;
        case (state_q)
            pgs_pkg::PGS_LOAD: begin
                load_d = 1'b1;
            end

            pgs_pkg::PGS_RESTORE: begin
                rest_d = 1'b1;
            end

            pgs_pkg::PGS_RUN: begin
                ok_d = 1'b1;
                clk_en_d = 1'b1;
                pll_d = 1'b1;
            end

            pgs_pkg::PGS_SLEEP: begin
                lp_d = 1'b1;
                if (sleep_mode && wake_ok) begin
                    lp_d = 1'b0;
                    rest_d = 1'b1;
                end
            end

            pgs_pkg::PGS_RESET: begin
                crst_d = 1'b0;
                if (wake_ok) begin
                    crst_d = 1'b1;
                end
            end

            default: begin
                ok_d = 1'b0;
                clk_en_d = 1'b0;
                pll_d = 1'b0;
            end
        endcase
        if (!rst_b) begin
            ok_d = 1'b0;
            clk_en_d = 1'b0;
            pll_d = 1'b0;
            lp_d = 1'b0;
            crst_d = 1'b0;
            load_d = 1'b0;
            rest_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        ok_q <= ok_d;
        clk_en_q <= clk_en_d;
        pll_q <= pll_d;
        lp_q <= lp_d;
        crst_q <= crst_d;
        load_q <= load_d;
        rest_q <= rest_d;
    end

    // every output straight from its flip-flop
    assign supply_ok_indication = ok_q;
    assign clocks_enable = clk_en_q;
    assign analog_pll_enable = pll_q;
    assign low_power_active = lp_q;
    assign core_reset_b = crst_q;
    assign cfg_load_pulse = load_q;
    assign cfg_restore_pulse = rest_q;
    assign active_cfg = cfg_q;
endmodule

// file: tb/pgs_supervisor.sv
// Purpose: board supervisor model driving the power-good pin
// Assumes: rails reported as level flags
// Notes: pin low until rails valid for HOLD cycles and release asked
`timescale 1ns/1ps
module pgs_supervisor #(
    parameter int N = 4,
    parameter int HOLD = 8
) (
    input wire logic clk,
    input wire logic release_req,
    input wire logic [N-1:0] rails,
    output logic pin
);
    int cnt = 0;
    always @(posedge clk) begin
        cnt <= (&rails) ? ((cnt < HOLD) ? cnt + 1 : cnt) : 0;
    end
    assign pin = release_req && cnt >= HOLD;
endmodule

// file: tb/pgs_top_sva.sv
// Purpose: port checks for the power-good pin sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: bound into pgs_top
`timescale 1ns/1ps
module pgs_top_chk #(
    parameter int SUPPLY_N = pgs_pkg::SUPPLY_N,
    parameter int CFG_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic power_ok_pin,
    input wire logic [1:0] pin_function,
    input wire logic [SUPPLY_N-1:0] supply_valid,
    input wire logic supply_ok_indication,
    input wire logic clocks_enable,
    input wire logic analog_pll_enable,
    input wire logic low_power_active,
    input wire logic core_reset_b,
    input wire logic cfg_load_pulse,
    input wire logic cfg_restore_pulse,
    input wire logic [CFG_W-1:0] active_cfg
);
    logic gated;
    assign gated = pin_function == pgs_pkg::FUNC_SLEEP || pin_function == pgs_pkg::FUNC_REBOOT;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_pin_low_holds: assert property ((gated && !power_ok_pin) [*6] |-> !clocks_enable)
        else $error("clocks on while pin low");
    a_ok_with_clocks: assert property (supply_ok_indication == clocks_enable)
        else $error("power ok and clocks disagree");
    a_load_to_run: assert property (cfg_load_pulse |-> ##[1:2] clocks_enable)
        else $error("no run after load");
    a_sleep_pll_off: assert property (low_power_active |-> !analog_pll_enable && !clocks_enable)
        else $error("pll or clocks on in sleep");
    a_restore_keeps_cfg: assert property (cfg_restore_pulse |-> $stable(active_cfg) ##1 $stable(active_cfg))
        else $error("config changed on restore");
    a_reboot_gates: assert property (!core_reset_b |-> !clocks_enable && !low_power_active)
        else $error("outputs active in restart");
    a_one_function: assert property (!gated |-> !low_power_active && !cfg_restore_pulse)
        else $error("pin function acted when disabled");
    a_rails_gate: assert property ($rose(clocks_enable) |-> $past(&supply_valid))
        else $error("clocks rose without all rails");
    a_load_once: assert property (cfg_load_pulse |=> !cfg_load_pulse)
        else $error("load pulse longer than one cycle");
    c_load: cover property (cfg_load_pulse);
    c_restore: cover property (cfg_restore_pulse);
    c_sleep: cover property (low_power_active);
endmodule
bind pgs_top pgs_top_chk #(.SUPPLY_N(SUPPLY_N), .CFG_W(CFG_W)) chk_u (.clk(clk), .rst_b(rst_b),
    .power_ok_pin(power_ok_pin), .pin_function(pin_function), .supply_valid(supply_valid),
    .supply_ok_indication(supply_ok_indication), .clocks_enable(clocks_enable),
    .analog_pll_enable(analog_pll_enable), .low_power_active(low_power_active),
    .core_reset_b(core_reset_b), .cfg_load_pulse(cfg_load_pulse),
    .cfg_restore_pulse(cfg_restore_pulse), .active_cfg(active_cfg));

// file: tb/power_good_pin_sequencer_tb.sv
// Purpose: self-checking bench for the power-good pin sequencer
// Assumes: supervisor model drives the pin
// Notes: every pin function is run from reset
`timescale 1ns/1ps
module power_good_pin_sequencer_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic pin;
    logic go = 1'b0;
    logic [1:0] func = 2'h0;
    logic [3:0] rails = 4'h0;
    logic [1:0] sel = 2'h0;
    logic wr_en = 1'b0;
    logic [1:0] wr_addr = 2'h0;
    logic [15:0] wr_data = 16'h0000;
    logic ok, clk_en, pll_en, lp, crst_b, ld, rs;
    logic [15:0] cfg, old;
    logic [15:0] lfsr = 16'h005F;
    logic [15:0] mem [4];
    int n_errors = 0;
    int checks = 0;
    int n_load = 0;
    int n_rest = 0;
    int nl, nr, f;
    pgs_top dut_u (.clk(clk), .rst_b(rst_b), .power_ok_pin(pin), .pin_function(func),
        .supply_valid(rails), .cfg_select(sel), .cfg_wr_en(wr_en), .cfg_wr_addr(wr_addr),
        .cfg_wr_data(wr_data), .supply_ok_indication(ok), .clocks_enable(clk_en),
        .analog_pll_enable(pll_en), .low_power_active(lp), .core_reset_b(crst_b),
        .cfg_load_pulse(ld), .cfg_restore_pulse(rs), .active_cfg(cfg));
    pgs_supervisor sup_u (.clk(clk), .release_req(go), .rails(rails), .pin(pin));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        if (ld === 1'b1) n_load++;
        if (rs === 1'b1) n_rest++;
    end
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] exp_cfg(input logic [1:0] fn, input logic [15:0] o);
        return (fn == pgs_pkg::FUNC_REBOOT) ? mem[sel] : o;
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // bounded wait on the clock gate, then margin past the output latency
    task automatic settle(input logic e);
        for (int i = 0; i < 40 && clk_en !== e; i++) @(posedge clk);
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic do_reset(input logic [1:0] fn);
        @(posedge clk);
        rst_b <= 1'b0;
        go <= 1'b0;
        func <= fn;
        rails <= lfsr[3:0] & 4'h7;
        for (int i = 0; i < 4; i++) begin
            lfsr = nx(lfsr);
            mem[i] = lfsr;
            wr_en <= 1'b1;
            wr_addr <= 2'(i);
            wr_data <= lfsr;
            @(posedge clk);
        end
        wr_en <= 1'b0;
        rst_b <= 1'b1;
        sel <= lfsr[5:4];
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        for (f = 0; f < 4; f++) begin
            do_reset(2'(f));
            settle(1'b0);
            chk(16'(clk_en), 16'h0000);
            @(posedge clk) rails <= 4'hF;
            settle(1'b1);
            chk(16'(clk_en), 16'(f == 0 || f == 3));
            @(posedge clk) go <= 1'b1;
            settle(1'b1);
            chk(16'({clk_en, pll_en, ok}), 16'h0007);
            if (f == 1 || f == 2) begin
                chk(cfg, mem[sel]);
                nl = n_load;
                nr = n_rest;
                old = cfg;
                @(posedge clk) go <= 1'b0;
                sel <= sel + 2'h1;
                settle(1'b0);
                chk(16'({lp, pll_en, crst_b}), 16'(f == 1 ? 3'h5 : 3'h0));
                @(posedge clk) go <= 1'b1;
                settle(1'b1);
                chk(cfg, exp_cfg(func, old));
                chk(16'(n_load - nl), 16'(f == 2));
                chk(16'(n_rest - nr), 16'(f == 1));
            end
        end
        complete_run;
    end
    // four scenarios need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        complete_run;
    end
endmodule
